// ==== include/two_wire_pkg.sv ====
package two_wire_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] ADR_CTL  = 8'he8;
	localparam logic [7:0] ADR_A0   = 8'h9b;
	localparam logic [7:0] ADR_A1   = 8'h91;
	localparam logic [7:0] ADR_A2   = 8'h92;
	localparam logic [7:0] ADR_A3   = 8'h93;
	localparam logic [7:0] ADR_DATA = 8'h9a;

	// ==========================================================
	// reset values
	localparam logic [7:0] A0_RST   = 8'h55;
	localparam logic [7:0] AX_RST   = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	// ==========================================================
	// control bit positions, master view then slave view
	localparam int B_MDO  = 7;
	localparam int B_MDE  = 6;
	localparam int B_MCO  = 5;
	localparam int B_MODE = 3;
	localparam int B_SI   = 7;
	localparam int B_GC   = 6;
	localparam int B_RS   = 2;
	localparam int B_DONE = 0;

	// ==========================================================
	// interrupt source codes and special address
	localparam logic [1:0] ID_START   = 2'h0;
	localparam logic [1:0] ID_RESTART = 2'h1;
	localparam logic [1:0] ID_DATA    = 2'h2;
	localparam logic [1:0] ID_STOP    = 2'h3;
	localparam logic [7:0] GC_ADDR    = 8'h00;

	// ==========================================================
	// timing: spike filter length in link clock cycles
	localparam int         GLITCH_NS   = 50;
	localparam int         LINK_CLK_NS = 48;
	localparam logic [1:0] FILT_CYC    = 2'((GLITCH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS);

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} pin_in_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} pin_out_t;

	typedef struct packed {
		logic master;
		logic soft_master_data_out;
		logic soft_master_data_drive_enable;
		logic soft_master_clock_out;
		logic soft_rst;
		logic blocked;
	} ctl_cfg_t;

	typedef struct packed {
		logic [1:0] code;
		logic       gc;
		logic [7:0] dat;
	} link_ev_t;

	typedef enum logic [2:0] {
		L_IDLE, L_ADDR, L_ACK_WAIT, L_ACK_HOLD, L_RX, L_TX, L_TX_ACK, L_TX_LOAD
	} link_state_t;

endpackage

// ==== core/sync_2ff.sv ====
`timescale 1ns/1ps
`default_nettype none

// two-flop level synchroniser
module sync_2ff #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		meta_q <= d;
		q      <= meta_q;
	end

endmodule

`default_nettype wire

// ==== core/glitch_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

// synchronise a pin and reject short spikes
module glitch_filter (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin level
	input  wire logic raw,
	output logic      filt
);
	import two_wire_pkg::*;

	typedef struct packed {
		logic [1:0] cnt;
		logic       filt;
	} filt_state_t;

	filt_state_t fq;
	filt_state_t fn;
	logic        s;

	sync_2ff #(.W(1)) u_sync (
		.clk (clk),
		.d   (raw),
		.q   (s)
	);

	// new level must persist longer than a spike
	always_comb begin
		fn = fq;
		if (s == fq.filt) begin
			fn.cnt = 2'h0;
		end else if (fq.cnt == FILT_CYC) begin
			fn.filt = s; // R18
			fn.cnt  = 2'h0;
		end else begin
			fn.cnt = fq.cnt + 2'h1;
		end
		if (rst) begin
			fn.cnt  = 2'h0;
			fn.filt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		fq <= fn;
	end

	assign filt = fq.filt;

endmodule

`default_nettype wire

// ==== core/two_wire_iface.sv ====
// Behaviour
// R01: runs only when sync port off or relocated
// R02: master data bit driven when enable set
// R03: enable bit sets data pin direction
// R04: master clock bit drives clock pin
// R05: data pin captured on clock when undriven
// R06: mode bit picks software master or slave
// R07: stop after matched start raises interrupt
// R08: general call sets sticky bit, software clears
// R09: source code 00,01,10,11 per event
// R10: soft reset bit holds slave in reset
// R11: direction flag set while slave transmits
// R12: byte done flag set per byte
// R13: reading data register clears byte flag
// R14: first address resets 55h, all writable
// R15: seven-bit address compare on incoming byte
// R16: four programmable slave addresses matched
// R17: any data register access clears interrupt
// R18: spikes under 50 ns filtered out
// R19: master mode silences slave machine
`timescale 1ns/1ps
`default_nettype none

module two_wire_iface (
	// core clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// register port
	input  wire two_wire_pkg::sfr_req_t sfr_req,
	output logic [7:0]                  sfr_rdata,
	// pin sharing with the sync port
	input  wire logic                   sync_port_enable,
	input  wire logic                   port_relocated,
	// interrupt
	output logic                        irq,
	// link clock and pins
	input  wire logic                   line_clk,
	input  wire two_wire_pkg::pin_in_t  pin_in,
	output var two_wire_pkg::pin_out_t  pin_out
);
	import two_wire_pkg::*;

	// ==========================================================
	// state types
	typedef struct packed {
		logic [7:0]      rdata;
		logic            irq;
		ctl_cfg_t        cfg;
		logic            si;
		logic            gc_seen;
		logic [1:0]      idc;
		logic            done;
		logic            stop_pend;
		logic [3:0][7:0] adr;
		logic [7:0]      txd;
		logic [7:0]      rxd;
		logic            cfg_tgl;
		logic            ev_seen;
	} core_state_t;

	typedef struct packed {
		link_state_t     st;
		logic [3:0]      bitcnt;
		logic [7:0]      sh;
		logic            rw;
		logic            busy;
		logic            matched;
		logic            hold_low;
		logic [3:0][7:0] adr;
		logic [7:0]      txd;
		logic            cfg_seen;
		logic            scl_prev;
		logic            sda_prev;
		logic            ev_tgl;
		logic            dir;
		logic            soft_master_data_in;
		link_ev_t        ev;
		pin_out_t        pins;
	} line_state_t;

	core_state_t cq;
	core_state_t cn;
	line_state_t lq;
	line_state_t ln;

	// ==========================================================
	// crossings
	logic       lrst;
	logic       scl_f;
	logic       sda_f;
	ctl_cfg_t   cfg_s;
	logic       cfg_tgl_s;
	logic       ev_s;
	logic [1:0] lvl_s;

	// core reset into the link domain
	sync_2ff #(.W(1)) u_rst_sync (
		.clk (line_clk),
		.d   (rst),
		.q   (lrst)
	);

	// control levels into the link domain
	sync_2ff #(.W(7)) u_cfg_sync (
		.clk (line_clk),
		.d   ({cq.cfg, cq.cfg_tgl}),
		.q   ({cfg_s, cfg_tgl_s})
	);

	// event toggle and status levels into the core domain
	sync_2ff #(.W(3)) u_ev_sync (
		.clk (core_clk),
		.d   ({lq.ev_tgl, lq.dir, lq.soft_master_data_in}),
		.q   ({ev_s, lvl_s})
	);

	// spike filters on both lines
	glitch_filter u_scl_filt (
		.clk  (line_clk),
		.rst  (lrst),
		.raw  (pin_in.scl),
		.filt (scl_f)
	);

	glitch_filter u_sda_filt (
		.clk  (line_clk),
		.rst  (lrst),
		.raw  (pin_in.sda),
		.filt (sda_f)
	);

	// ==========================================================
	// core domain: register file and flags
	logic       ev_new;
	logic       slave_live;
	logic       dat_access;
	logic [7:0] ctl_view;
	logic [7:0] rd_mux;
	logic [7:0] w;

	always_comb begin
		cn         = cq;
		w          = sfr_req.wdata;
		ev_new     = (ev_s != cq.ev_seen);
		cn.ev_seen = ev_s;
		cn.cfg.blocked = sync_port_enable & ~port_relocated; // R01
		slave_live = ~cq.cfg.master & ~cq.cfg.soft_rst & ~cq.cfg.blocked; // R19
		// control view depends on mode
		if (cq.cfg.master) begin // R06
			ctl_view = {cq.cfg.soft_master_data_out, cq.cfg.soft_master_data_drive_enable, cq.cfg.soft_master_clock_out, lvl_s[0], 1'b1, 3'h0};
		end else begin
			ctl_view = {cq.si, cq.gc_seen, cq.idc, 1'b0, cq.cfg.soft_rst, lvl_s[1], cq.done};
		end
		unique case (sfr_req.addr)
			ADR_CTL:  rd_mux = ctl_view;
			ADR_A0:   rd_mux = cq.adr[0];
			ADR_A1:   rd_mux = cq.adr[1];
			ADR_A2:   rd_mux = cq.adr[2];
			ADR_A3:   rd_mux = cq.adr[3];
			ADR_DATA: rd_mux = cq.rxd;
			default:  rd_mux = 8'h00;
		endcase
		if (sfr_req.rd) begin
			cn.rdata = rd_mux;
		end
		// data register access drops the pending interrupt
		dat_access = (sfr_req.rd | sfr_req.wr) && (sfr_req.addr == ADR_DATA);
		if (dat_access) begin
			cn.done      = 1'b0; // R13
			cn.stop_pend = 1'b0; // R17
		end
		// register writes
		if (sfr_req.wr) begin
			unique case (sfr_req.addr)
				ADR_CTL: begin
					cn.cfg.master = w[B_MODE]; // R06
					if (cq.cfg.master) begin
						cn.cfg.soft_master_data_out = w[B_MDO];
						cn.cfg.soft_master_data_drive_enable = w[B_MDE];
						cn.cfg.soft_master_clock_out = w[B_MCO];
					end else begin
						cn.si           = w[B_SI];
						cn.cfg.soft_rst = w[B_RS];
						if (!w[B_GC]) begin
							cn.gc_seen = 1'b0;
						end
						if (!w[B_DONE]) begin
							cn.done = 1'b0;
						end
					end
				end
				ADR_A0: cn.adr[0] = w; // R14
				ADR_A1: cn.adr[1] = w;
				ADR_A2: cn.adr[2] = w; // R16
				ADR_A3: cn.adr[3] = w;
				ADR_DATA: cn.txd  = w;
				default: ;
			endcase
			if (sfr_req.addr inside {ADR_A0, ADR_A1, ADR_A2, ADR_A3, ADR_DATA}) begin
				cn.cfg_tgl = ~cq.cfg_tgl;
			end
		end
		// soft reset clears the done and stop pending flags from the write edge on
		if (cn.cfg.soft_rst && !cn.cfg.master) begin
			cn.done      = 1'b0; // R10
			cn.stop_pend = 1'b0;
		end
		// events from the link win over clears
		if (ev_new && slave_live) begin
			cn.idc = lq.ev.code; // R09
			if (lq.ev.code == ID_STOP) begin
				if (cq.si) begin
					cn.stop_pend = 1'b1; // R07
				end
			end else begin
				cn.done = 1'b1; // R12
				cn.rxd  = lq.ev.dat;
			end
			if (lq.ev.gc) begin
				cn.gc_seen = 1'b1; // R08
			end
		end
		cn.irq = cn.done | cn.stop_pend;
		if (rst) begin
			cn        = '0;
			cn.adr[0] = A0_RST; // R14
			cn.adr[1] = AX_RST;
			cn.adr[2] = AX_RST;
			cn.adr[3] = AX_RST;
			cn.txd    = DATA_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		cq <= cn;
	end

	assign sfr_rdata = cq.rdata;
	assign irq       = cq.irq;

	// ==========================================================
	// link domain: pins and slave machine
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;
	logic       off;
	logic       hit;
	logic       gc_hit;
	logic [7:0] sh_in;

	always_comb begin
		ln          = lq;
		ln.scl_prev = scl_f;
		ln.sda_prev = sda_f;
		rise  = scl_f & ~lq.scl_prev;
		fall  = ~scl_f & lq.scl_prev;
		start = scl_f & lq.scl_prev & lq.sda_prev & ~sda_f;
		stop  = scl_f & lq.scl_prev & ~lq.sda_prev & sda_f;
		off   = cfg_s.soft_rst | cfg_s.master | cfg_s.blocked;
		sh_in = {lq.sh[6:0], sda_f};
		// compare against every programmed address
		hit = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (lq.adr[i][6:0] == sh_in[7:1]) begin
				hit = 1'b1; // R15 R16
			end
		end
		gc_hit = (sh_in == GC_ADDR);
		// take fresh addresses and transmit byte after a core write
		ln.cfg_seen = cfg_tgl_s;
		if (cfg_tgl_s != lq.cfg_seen) begin
			ln.adr = cq.adr;
			ln.txd = cq.txd;
		end
		// software master sampling
		if (cfg_s.master && !cfg_s.soft_master_data_drive_enable && rise) begin
			ln.soft_master_data_in = sda_f; // R05
		end
		if (off) begin
			ln.st       = L_IDLE; // R10 R19
			ln.busy     = 1'b0;
			ln.matched  = 1'b0;
			ln.hold_low = 1'b0;
			ln.dir      = 1'b0;
		end else if (start) begin
			ln.st       = L_ADDR;
			ln.bitcnt   = 4'h0;
			ln.hold_low = 1'b0;
			ln.busy     = 1'b1;
			ln.rw       = lq.busy; // remembers repeated start
			ln.dir      = 1'b0;
		end else if (stop) begin
			if (lq.busy && lq.matched) begin
				ln.ev     = '{ID_STOP, 1'b0, lq.sh}; // R07 R09
				ln.ev_tgl = ~lq.ev_tgl;
			end
			ln.st       = L_IDLE;
			ln.busy     = 1'b0;
			ln.matched  = 1'b0;
			ln.hold_low = 1'b0;
			ln.dir      = 1'b0;
		end else begin
			unique case (lq.st)
				L_IDLE: ;
				L_ADDR: begin
					if (rise) begin
						ln.sh     = sh_in;
						ln.bitcnt = lq.bitcnt + 4'h1;
						if (lq.bitcnt == 4'h7) begin
							ln.matched = hit | gc_hit;
							if (hit || gc_hit) begin
								ln.st     = L_ACK_WAIT;
								ln.ev     = '{(lq.rw ? ID_RESTART : ID_START), gc_hit, sh_in}; // R09
								ln.ev_tgl = ~lq.ev_tgl;
								ln.rw     = sh_in[0];
								ln.dir    = sh_in[0]; // R11
							end else begin
								ln.st = L_IDLE;
							end
						end
					end
				end
				L_ACK_WAIT: begin
					if (fall) begin
						ln.hold_low = 1'b1;
						ln.st       = L_ACK_HOLD;
					end
				end
				L_ACK_HOLD: begin
					if (fall) begin
						ln.bitcnt = 4'h0;
						if (lq.rw) begin
							ln.sh       = lq.txd;
							ln.hold_low = ~lq.txd[7];
							ln.st       = L_TX;
						end else begin
							ln.hold_low = 1'b0;
							ln.st       = L_RX;
						end
					end
				end
				L_RX: begin
					if (rise) begin
						ln.sh     = sh_in;
						ln.bitcnt = lq.bitcnt + 4'h1;
						if (lq.bitcnt == 4'h7) begin
							ln.ev     = '{ID_DATA, 1'b0, sh_in}; // R12
							ln.ev_tgl = ~lq.ev_tgl;
							ln.st     = L_ACK_WAIT;
						end
					end
				end
				L_TX: begin
					if (rise) begin
						ln.bitcnt = lq.bitcnt + 4'h1;
					end else if (fall) begin
						if (lq.bitcnt == 4'h8) begin
							ln.hold_low = 1'b0;
							ln.st       = L_TX_ACK;
						end else begin
							ln.sh       = {lq.sh[6:0], 1'b0};
							ln.hold_low = ~lq.sh[6];
						end
					end
				end
				L_TX_ACK: begin
					if (rise) begin
						ln.ev     = '{ID_DATA, 1'b0, lq.txd}; // R12
						ln.ev_tgl = ~lq.ev_tgl;
						ln.st     = sda_f ? L_IDLE : L_TX_LOAD;
					end
				end
				L_TX_LOAD: begin
					if (fall) begin
						ln.bitcnt   = 4'h0;
						ln.sh       = lq.txd;
						ln.hold_low = ~lq.txd[7];
						ln.st       = L_TX;
					end
				end
			endcase
		end
		// pin drive per mode
		if (cfg_s.blocked) begin
			ln.pins = '0; // R01
		end else if (cfg_s.master) begin
			ln.pins.scl_o  = cfg_s.soft_master_clock_out; // R04
			ln.pins.scl_oe = 1'b1;
			ln.pins.sda_o  = cfg_s.soft_master_data_out; // R02
			ln.pins.sda_oe = cfg_s.soft_master_data_drive_enable; // R03
		end else begin
			ln.pins.scl_o  = 1'b0;
			ln.pins.scl_oe = 1'b0;
			ln.pins.sda_o  = 1'b0;
			ln.pins.sda_oe = ln.hold_low;
		end
		if (lrst) begin
			ln          = '0;
			ln.scl_prev = 1'b1;
			ln.sda_prev = 1'b1;
			ln.adr[0]   = A0_RST;
		end
	end

	always_ff @(posedge line_clk) begin
		lq <= ln;
	end

	assign pin_out = lq.pins;

endmodule

`default_nettype wire

// ==== bench/two_wire_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module two_wire_monitor (
	// core side
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire two_wire_pkg::sfr_req_t sfr_req,
	input  wire logic [7:0]             sfr_rdata,
	input  wire logic                   sync_port_enable,
	input  wire logic                   port_relocated,
	input  wire logic                   irq,
	// link side
	input  wire logic                   line_clk,
	input  wire two_wire_pkg::pin_in_t  pin_in,
	input  wire two_wire_pkg::pin_out_t pin_out
);
	import two_wire_pkg::*;

	// ==========================================================
	// access decode
	wire logic dat_acc = (sfr_req.rd || sfr_req.wr) && sfr_req.addr == ADR_DATA;
	wire logic ctl_wr  = sfr_req.wr && sfr_req.addr == ADR_CTL;
	wire logic known   = sfr_req.addr inside {ADR_CTL, ADR_A0, ADR_A1, ADR_A2, ADR_A3, ADR_DATA};

	// ==========================================================
	// register port
	property p_unmapped;
		@(posedge core_clk) disable iff (rst) sfr_req.rd && !known |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_data_clr;
		@(posedge core_clk) disable iff (rst) dat_acc |=> !irq;
	endproperty
	a_data_clr: assert property (p_data_clr) else $error("irq kept after data access");
	property p_irq_hold;
		@(posedge core_clk) disable iff (rst) irq && !dat_acc && !ctl_wr |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
	property p_rdata_hold;
		@(posedge core_clk) disable iff (rst) !sfr_req.rd |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_ctl_view;
		@(posedge core_clk) disable iff (rst) sfr_req.rd && sfr_req.addr == ADR_CTL
			|=> !sfr_rdata[3] || sfr_rdata[2:0] == 3'h0;
	endproperty
	a_ctl_view: assert property (p_ctl_view) else $error("master view low bits set");
	property p_blocked;
		@(posedge core_clk) disable iff (rst)
			(sync_port_enable && !port_relocated) [*8] |-> pin_out == 4'h0;
	endproperty
	a_blocked: assert property (p_blocked) else $error("pins driven while port shared");

	// ==========================================================
	// pins
	property p_slave_sda;
		@(posedge line_clk) disable iff (rst) !pin_out.scl_oe |-> !pin_out.sda_o;
	endproperty
	a_slave_sda: assert property (p_slave_sda) else $error("slave drives data high");
	property p_sda_edge;
		@(posedge line_clk) disable iff (rst)
			$changed(pin_out.sda_oe) && !pin_out.scl_oe && !$past(pin_out.scl_oe) |-> !pin_in.scl;
	endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");

	// main scenarios
	c_irq: cover property (@(posedge core_clk) $rose(irq));
	c_ack: cover property (@(posedge line_clk) $rose(pin_out.sda_oe));
	c_dat: cover property (@(posedge core_clk) dat_acc);
endmodule

bind two_wire_iface two_wire_monitor u_mon (.core_clk, .rst, .sfr_req, .sfr_rdata,
	.sync_port_enable, .port_relocated, .irq, .line_clk, .pin_in, .pin_out);

`default_nettype wire

// ==== bench/bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module bus_master_model #(
	parameter int H = 12
) (
	// link clock
	input  wire logic clk,
	// wire levels
	input  wire logic scl,
	input  wire logic sda,
	// open-drain pulls
	output logic      scl_low,
	output logic      sda_low
);
	// released lines at start
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	task automatic half();
		repeat (H) @(negedge clk);
	endtask

	// one bit, data moved only well after the clock fall
	task automatic bit_x(input logic v, output logic r);
		repeat (3) @(negedge clk);
		sda_low = ~v;
		half();
		scl_low = 1'b0;
		half();
		r = sda;
		scl_low = 1'b1;
	endtask

	// start or repeated start: data falls while clock high
	task automatic start();
		half();
		sda_low = 1'b0;
		half();
		scl_low = 1'b0;
		half();
		sda_low = 1'b1;
		half();
		scl_low = 1'b1;
	endtask

	// stop: data rises while clock high
	task automatic stop();
		half();
		sda_low = 1'b1;
		half();
		scl_low = 1'b0;
		half();
		sda_low = 1'b0;
		half();
	endtask

	// byte out msb first, then the slave's acknowledge
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], r);
		end
		bit_x(1'b1, ack);
	endtask

	// byte in, then our acknowledge level
	task automatic get(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_x(1'b1, r);
			b = {b[6:0], r};
		end
		bit_x(nack, r);
	endtask
endmodule

`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import two_wire_pkg::*;

	// ==========================================================
	// signals
	logic        core_clk, line_clk, rst, sync_port_enable, port_relocated, irq, rd_seen, ack, spike;
	sfr_req_t    sfr_req;
	logic [7:0]  sfr_rdata, a1, d, t, b;
	pin_in_t     pin_in;
	pin_out_t    pin_out;
	wire logic   scl_low, sda_low;
	logic [7:0]  expq[$];
	logic [15:0] seed = 16'h9460;
	int          fails = 0, comparisons = 0, cycles = 0;

	// open-drain wires with pull-ups, clock push-pull in master mode, short clock spikes
	assign pin_in = {(pin_out.scl_oe ? pin_out.scl_o : ~scl_low) & ~spike,
		~(sda_low | (pin_out.sda_oe & ~pin_out.sda_o))};

	two_wire_iface DUT (.core_clk, .rst, .sfr_req, .sfr_rdata, .sync_port_enable,
		.port_relocated, .irq, .line_clk, .pin_in, .pin_out);
	bus_master_model BM (.clk(line_clk), .scl(pin_in.scl), .sda(pin_in.sda),
		.scl_low(scl_low), .sda_low(sda_low));

	// core clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// link clock, offset phase
	initial begin
		line_clk = 1'b0;
		#7;
		forever #24 line_clk = ~line_clk;
	end

	// ==========================================================
	// helpers
	function automatic logic [7:0] nxt();
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
		return seed[7:0];
	endfunction
	task automatic check(input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, v);
		@(negedge core_clk);
		sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
		@(negedge core_clk);
		sfr_req.wr = 1'b0;
		idle(10);
	endtask
	task automatic rd(input logic [7:0] a, v);
		@(negedge core_clk);
		sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		expq.push_back(v);
		@(negedge core_clk);
		sfr_req.rd = 1'b0;
	endtask
	task automatic stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// read results against oldest note, plus hang limit
	always @(posedge core_clk) begin
		if (rd_seen) begin
			check(sfr_rdata, expq.pop_front());
		end
		rd_seen = sfr_req.rd;
		cycles++;
		if (cycles == 30000) begin
			fails++;
			stop_test();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		sfr_req = '0;
		spike = 1'b0;
		sync_port_enable = 1'b0;
		port_relocated = 1'b0;
		rd_seen = 1'b0;
		rst = 1'b1;
		idle(10);
		rst = 1'b0;
		rd(ADR_CTL, 8'h00);
		rd(ADR_A0, A0_RST);
		rd(ADR_A3, AX_RST);
		rd(8'h10, 8'h00);
		d = nxt();
		a1 = {2'b00, d[5:0]} | 8'h01;
		wr(ADR_A1, a1);
		rd(ADR_A1, a1);
		wr(ADR_CTL, 8'h80);
		$display("test registers finished");
		BM.start();
		BM.put({a1[6:0], 1'b0}, ack);
		check({7'h00, ack}, 8'h00);
		rd(ADR_CTL, 8'h81);
		rd(ADR_DATA, {a1[6:0], 1'b0});
		rd(ADR_CTL, 8'h80);
		d = nxt();
		// short clock spikes during the data byte must not add bits
		fork
			BM.put(d, ack);
			repeat (20) begin
				#470 spike = 1'b1;
				#30 spike = 1'b0;
			end
		join
		check({7'h00, ack}, 8'h00);
		rd(ADR_CTL, 8'ha1);
		rd(ADR_DATA, d);
		t = nxt();
		wr(ADR_DATA, t);
		BM.start();
		BM.put(8'hab, ack);
		check({7'h00, ack}, 8'h00);
		rd(ADR_CTL, 8'h93);
		rd(ADR_DATA, 8'hab);
		BM.get(1'b1, b);
		check(b, t);
		wr(ADR_DATA, t);
		check({7'h00, irq}, 8'h00);
		BM.stop();
		check({7'h00, irq}, 8'h01);
		wr(ADR_DATA, 8'h00);
		check({7'h00, irq}, 8'h00);
		rd(ADR_CTL, 8'hb0);
		$display("test slave transfer finished");
		BM.start();
		BM.put(8'h00, ack);
		check({7'h00, ack}, 8'h00);
		BM.stop();
		rd(ADR_CTL, 8'hf1);
		wr(ADR_CTL, 8'h80);
		rd(ADR_CTL, 8'hb0);
		$display("test general call finished");
		for (int k = 0; k < 4; k++) begin
			idle(1);
			sync_port_enable = (k == 0 || k == 2);
			port_relocated = (k == 2);
			wr(ADR_CTL, k == 1 ? 8'h84 : 8'h80);
			BM.start();
			BM.put(k == 3 ? 8'hfc : {a1[6:0], 1'b0}, ack);
			BM.stop();
			check({7'h00, ack}, {7'h00, k != 2});
		end
		wr(ADR_A3, 8'h7e);
		BM.start();
		BM.put(8'hfc, ack);
		BM.stop();
		check({7'h00, ack}, 8'h00);
		$display("test refusals finished");
		for (int k = 0; k < 8; k++) begin
			wr(ADR_CTL, {k[2:0], 5'h08});
			check({4'h0, pin_out}, {4'h0, k[0], 1'b1, k[2], k[1]});
		end
		BM.sda_low = 1'b1;
		wr(ADR_CTL, 8'h08);
		wr(ADR_CTL, 8'h28);
		idle(20);
		rd(ADR_CTL, 8'h28);
		BM.sda_low = 1'b0;
		wr(ADR_CTL, 8'h08);
		wr(ADR_CTL, 8'h28);
		idle(20);
		rd(ADR_CTL, 8'h38);
		idle(4);
		$display("test master mode finished");
		stop_test();
	end
endmodule

`default_nettype wire
